// File: rtl/etu_core.sv
// Purpose: exception classification and trace trap logic of the core
// Assumes: core events are synchronous one-cycle pulses on clk_i
// Notes:   register bus is classic wishbone, one wait state per access
//
// Behaviour
// RQ1: every exception writes class field and state code into status word
// RQ2: class encoding normal 11, stack 01, process 10, reset 00
// RQ3: normal class state codes as per table
// RQ4: stack, process and reset class state codes as per table
// RQ5: reset class acts like external reset; higher class wins
// RQ6: trap completes instruction, saved pc points to next instruction
// RQ7: non-trap exception leaves saved pc at faulting opcode
// RQ8: breakpoint instruction always raises breakpoint trap
// RQ9: overflow trap when enable set and overflow flag ends at one
// RQ10: overflow trap clears overflow enable before status word save
// RQ11: back-to-back overflowing instructions yield only one trap
// RQ12: alignment faults only on misaligned word or halfword data accesses
// RQ13: memory fault on misalignment, fault input, coprocessor status or silence
// RQ14: gate return raising privilege and gate table fault raise exceptions
// RQ15: kernel opcode outside kernel, undefined and reserved opcodes fault
// RQ16: privileged register write outside kernel raises exception
// RQ17: zero-divide, invalid descriptor, privileged register, data type clear flags
// RQ18: invalid descriptor on literal destination or bad effective address
// RQ19: trace detected at instruction end, before interrupts
// RQ20: trace trap only when enable and mask are both one
// RQ21: mask set at instruction start, cleared on switch, gate return, fault
// RQ22: process return, process call, gate return are never traced
`timescale 1ns/1ps
`default_nettype none
`include "etu_consts.svh"

module etu_core
	import etu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	input  wire logic        instr_start_i,
	input  wire logic        instr_end_i,
	input  wire logic        no_trace_instr_i,
	input  wire logic [1:0]  level_i,
	input  wire etu_norm_t   norm_i,
	input  wire etu_acc_t    acc_i,
	input  wire logic        cop_status_fault_i,
	input  wire logic        cop_no_answer_i,
	input  wire etu_sys_t    sys_i,
	input  wire logic        flags_we_i,
	input  wire logic [3:0]  flags_i,
	input  wire logic        psw_load_i,
	input  wire logic        psw_load_te_i,
	input  wire logic        psw_load_oe_i,
	input  wire logic        ctx_switch_i,
	input  wire logic        gate_ret_seq_i,
	input  wire logic        irq_taken_i,
	output etu_rpt_t         exc_o,
	output logic             exc_valid_o,
	output logic             reset_req_o,
	output logic             align_abort_o,
	output logic             irq_inhibit_o,
	output logic             te_o,
	output logic             tm_o,
	output logic             oe_o,
	output logic [3:0]       flags_o
);

	logic        te_ff, tm_ff, oe_ff, exc_valid_ff, reset_req_ff, ack_ff;
	logic [3:0]  flags_ff;
	etu_rpt_t    rpt_ff;
	logic [31:0] rdat_ff;

	logic        misalign, mem_fault, kernel, v_end, ovf_hit, trace_hit;
	logic        sel_v, sel_trap, sel_clr, ovf_take, trace_take, wb_req;
	logic [1:0]  sel_cls;
	logic [3:0]  sel_code;
	logic [3:0]  wb_off;
	logic [31:0] nxt_rdat;

	assign kernel = (level_i == `ETU_LVL_KERNEL);

	// fetches and bytes never fault; sizes tested on data accesses only
	assign misalign = acc_i.valid && !acc_i.fetch
		&& ((acc_i.size == `ETU_SZ_WORD && (acc_i.address_bit_one || acc_i.address_bit_zero))
		|| (acc_i.size == `ETU_SZ_HALF && acc_i.address_bit_zero)); // [RQ12]

	// the access is aborted before strobes go out, so no external cycle follows
	assign align_abort_o = misalign;
	assign mem_fault = misalign | (acc_i.valid & acc_i.ext_fault)
		| cop_status_fault_i | cop_no_answer_i; // [RQ13]

	// overflow seen with the flags as they stand once the instruction is done
	assign v_end = flags_we_i ? flags_i[0] : flags_ff[0];
	assign ovf_hit = instr_end_i & oe_ff & v_end; // [RQ9]
	assign trace_hit = instr_end_i & te_ff & tm_ff & !no_trace_instr_i; // [RQ20] [RQ22]
	// trace is decided in the uninterruptible tail, so interrupts wait for it
	assign irq_inhibit_o = trace_hit; // [RQ19]

	// highest class wins so a failing handler escalates upward
	always_comb
	begin
		sel_v = 1'b1;
		sel_cls = `ETU_CLS_NORMAL;
		sel_code = `ETU_N_ZDIV;
		sel_trap = 1'b0;
		sel_clr = 1'b0;
		if (sys_i.rst_old_pcb | sys_i.rst_sysdata | sys_i.rst_istack
			| sys_i.ext_reset | sys_i.rst_new_pcb | sys_i.rst_gatevec) // [RQ5]
		begin
			sel_cls = `ETU_CLS_RESET; // [RQ2]
			if (sys_i.rst_old_pcb)
				sel_code = `ETU_R_OLDPCB; // [RQ4]
			else if (sys_i.rst_sysdata)
				sel_code = `ETU_R_SYSDATA;
			else if (sys_i.rst_istack)
				sel_code = `ETU_R_ISTACK;
			else if (sys_i.ext_reset)
				sel_code = `ETU_R_EXTRST;
			else if (sys_i.rst_new_pcb)
				sel_code = `ETU_R_NEWPCB;
			else
				sel_code = `ETU_R_GATEVEC;
		end
		else if (sys_i.pcb_old_fault | sys_i.pcb_gate_fault | sys_i.pcb_new_fault)
		begin
			sel_cls = `ETU_CLS_PROCESS; // [RQ2]
			if (sys_i.pcb_old_fault)
				sel_code = `ETU_P_OLDPCB; // [RQ4]
			else if (sys_i.pcb_gate_fault)
				sel_code = `ETU_P_GATEPCB;
			else
				sel_code = `ETU_P_NEWPCB;
		end
		else if (sys_i.stack_bound | sys_i.stack_fault | sys_i.intid_fault)
		begin
			sel_cls = `ETU_CLS_STACK; // [RQ2]
			if (sys_i.stack_bound)
				sel_code = `ETU_S_BOUND; // [RQ4]
			else if (sys_i.stack_fault)
				sel_code = `ETU_S_FAULT;
			else
				sel_code = `ETU_S_INTID;
		end
		else if (norm_i.gate_table_fault)
			sel_code = `ETU_N_GATEVEC; // [RQ14]
		else if (mem_fault)
			sel_code = `ETU_N_MEMFLT; // [RQ13]
		else if (norm_i.gate_ret_raise)
			sel_code = `ETU_N_LVLCHG; // [RQ14]
		else if (norm_i.illegal_op)
			sel_code = `ETU_N_ILLOP; // [RQ15]
		else if (norm_i.reserved_op)
			sel_code = `ETU_N_RSVOP; // [RQ15]
		else if (norm_i.priv_op && !kernel)
			sel_code = `ETU_N_PRIVOP; // [RQ15]
		else if (norm_i.priv_reg_wr && !kernel)
		begin
			sel_code = `ETU_N_PRIVREG; // [RQ16]
			sel_clr = 1'b1; // [RQ17]
		end
		else if (norm_i.lit_dest | norm_i.ea_of_lit | norm_i.ea_of_reg)
		begin
			sel_code = `ETU_N_INVDESC; // [RQ18]
			sel_clr = 1'b1; // [RQ17]
		end
		else if (norm_i.reserved_dtype)
		begin
			sel_code = `ETU_N_RSVDT; // [RQ3]
			sel_clr = 1'b1; // [RQ17]
		end
		else if (norm_i.zero_divide)
		begin
			sel_code = `ETU_N_ZDIV; // [RQ3]
			sel_clr = 1'b1; // [RQ17]
		end
		else if (instr_end_i && norm_i.breakpoint_instr)
		begin
			sel_code = `ETU_N_BPT; // [RQ8]
			sel_trap = 1'b1; // [RQ6]
		end
		else if (ovf_hit)
		begin
			sel_code = `ETU_N_OVF; // [RQ9]
			sel_trap = 1'b1; // [RQ6]
		end
		else if (trace_hit)
		begin
			sel_code = `ETU_N_TRACE; // [RQ20]
			sel_trap = 1'b1; // [RQ6]
		end
		else
			sel_v = 1'b0;
	end

	assign ovf_take = sel_v && sel_trap && (sel_code == `ETU_N_OVF);
	assign trace_take = sel_v && sel_trap && (sel_code == `ETU_N_TRACE);

	// class and code land in the status word before handler entry
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rpt_ff <= '{`ETU_CLS_RESET, `ETU_R_EXTRST, 1'b0, 1'b0};
			exc_valid_ff <= 1'b0;
			reset_req_ff <= 1'b0;
		end
		else
		begin
			exc_valid_ff <= sel_v;
			reset_req_ff <= sel_v && (sel_cls == `ETU_CLS_RESET); // [RQ5]
			if (sel_v)
			begin
				rpt_ff.exception_class_field <= sel_cls; // [RQ1]
				rpt_ff.internal_state_code <= sel_code; // [RQ1]
				rpt_ff.trap <= sel_trap;
				rpt_ff.pc_at_next <= sel_trap; // [RQ6] [RQ7]
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flags_ff <= 4'h0;
		else if (sel_v && sel_clr)
			flags_ff <= 4'h0; // [RQ17]
		else if (flags_we_i)
			flags_ff <= flags_i;
	end

	// mask has no software path; start of instruction wins over a clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tm_ff <= 1'b0;
		else if (instr_start_i)
			tm_ff <= 1'b1; // [RQ21]
		else if (ctx_switch_i || gate_ret_seq_i || irq_taken_i || sel_v)
			tm_ff <= 1'b0; // [RQ21]
	end

	assign wb_req = wb_cyc_i & wb_stb_i & !ack_ff;
	assign wb_off = wb_adr_i[3:0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			te_ff <= 1'b0;
		else if (psw_load_i)
			te_ff <= psw_load_te_i;
		else if (wb_req && wb_we_i && wb_sel_i[0] && wb_off == `ETU_CTRL_OFF)
			te_ff <= wb_dat_i[`ETU_CTRL_TE];
	end

	// cleared on the trap itself, so a second overflow right behind finds it off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			oe_ff <= 1'b0;
		else if (ovf_take)
			oe_ff <= 1'b0; // [RQ10] [RQ11]
		else if (psw_load_i)
			oe_ff <= psw_load_oe_i;
		else if (wb_req && wb_we_i && wb_sel_i[0] && wb_off == `ETU_CTRL_OFF)
			oe_ff <= wb_dat_i[`ETU_CTRL_OE];
	end

	always_comb
	begin
		nxt_rdat = 32'h0000_0000;
		if (wb_adr_i[31:4] == 28'h0 && wb_off == `ETU_CTRL_OFF)
		begin
			nxt_rdat[`ETU_CTRL_TE] = te_ff;
			nxt_rdat[`ETU_CTRL_OE] = oe_ff;
		end
		else if (wb_adr_i[31:4] == 28'h0 && wb_off == `ETU_STAT_OFF)
		begin
			nxt_rdat[1:0] = rpt_ff.exception_class_field;
			nxt_rdat[`ETU_STAT_CODE +: 4] = rpt_ff.internal_state_code;
			nxt_rdat[`ETU_STAT_TE] = te_ff;
			nxt_rdat[`ETU_STAT_TM] = tm_ff;
			nxt_rdat[`ETU_STAT_FLAGS +: 4] = flags_ff;
			nxt_rdat[`ETU_STAT_OE] = oe_ff;
		end
	end

	// every address is acked; unmapped reads give zero, writes decode only the low four address bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= wb_req;
			if (wb_req && !wb_we_i)
				rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign exc_o = rpt_ff;
	assign exc_valid_o = exc_valid_ff;
	assign reset_req_o = reset_req_ff;
	assign te_o = te_ff;
	assign tm_o = tm_ff;
	assign oe_o = oe_ff;
	assign flags_o = flags_ff;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_align_word;
		acc_i.valid && !acc_i.fetch && acc_i.size == `ETU_SZ_WORD
			&& (acc_i.address_bit_one || acc_i.address_bit_zero)
			|-> align_abort_o && mem_fault;
	endproperty
	a_align_word: assert property (p_align_word) else $error("word misalign missed"); // [RQ12]
	property p_align_none;
		acc_i.fetch || acc_i.size == `ETU_SZ_BYTE |-> !align_abort_o;
	endproperty
	a_align_none: assert property (p_align_none) else $error("spurious align fault"); // [RQ12]
	property p_ext_reset;
		sys_i.ext_reset |=> exc_valid_o && reset_req_o
			&& exc_o.exception_class_field == `ETU_CLS_RESET;
	endproperty
	a_ext_reset: assert property (p_ext_reset) else $error("reset class not taken"); // [RQ5]
	property p_bpt;
		instr_end_i && norm_i.breakpoint_instr && !mem_fault && sys_i == '0
			&& norm_i[11:1] == '0
			|=> exc_valid_o && exc_o.trap && exc_o.internal_state_code == `ETU_N_BPT;
	endproperty
	a_bpt: assert property (p_bpt) else $error("breakpoint trap missed"); // [RQ8]
	property p_ovf_clear;
		ovf_take |=> !oe_o && exc_o.internal_state_code == `ETU_N_OVF;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow enable kept"); // [RQ10]
	property p_ovf_once;
		ovf_take |=> !ovf_take;
	endproperty
	a_ovf_once: assert property (p_ovf_once) else $error("double overflow trap"); // [RQ11]
	// judged on the reported code against the bits as they stood when it was decided
	property p_trace_cond;
		exc_valid_o && exc_o.exception_class_field == `ETU_CLS_NORMAL
			&& exc_o.internal_state_code == `ETU_N_TRACE |-> $past(te_o) && $past(tm_o);
	endproperty
	a_trace_cond: assert property (p_trace_cond) else $error("trace without mask"); // [RQ20]
	property p_mask_set;
		instr_start_i |=> tm_o;
	endproperty
	a_mask_set: assert property (p_mask_set) else $error("mask not set at start"); // [RQ21]
	property p_no_trace;
		instr_end_i && no_trace_instr_i |=> !(exc_valid_o && exc_o.internal_state_code
			== `ETU_N_TRACE && exc_o.exception_class_field == `ETU_CLS_NORMAL);
	endproperty
	a_no_trace: assert property (p_no_trace) else $error("untraceable traced"); // [RQ22]
	property p_flag_clr;
		exc_valid_o && exc_o.exception_class_field == `ETU_CLS_NORMAL && exc_o.internal_state_code
			inside {`ETU_N_ZDIV, `ETU_N_INVDESC, `ETU_N_PRIVREG, `ETU_N_RSVDT} |-> flags_o == 4'h0;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared"); // [RQ17]
	property p_pc_sel;
		exc_valid_o |-> exc_o.pc_at_next == (exc_o.exception_class_field == `ETU_CLS_NORMAL
			&& exc_o.internal_state_code inside {`ETU_N_TRACE, `ETU_N_OVF, `ETU_N_BPT});
	endproperty
	a_pc_sel: assert property (p_pc_sel) else $error("saved pc select wrong"); // [RQ7]
	property p_wb_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

	c_ovf: cover property (ovf_take);
	c_trace: cover property (trace_take);
	c_reset_cls: cover property (reset_req_o);
	c_align: cover property (align_abort_o ##1 exc_valid_o);

endmodule

`default_nettype wire

// File: pkg/etu_consts.svh
// Purpose: constants for the exception and trace unit
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on the register bus
`ifndef ETU_CONSTS_SVH
`define ETU_CONSTS_SVH

// exception class field values
`define ETU_CLS_NORMAL  2'h3
`define ETU_CLS_STACK   2'h1
`define ETU_CLS_PROCESS 2'h2
`define ETU_CLS_RESET   2'h0

// internal state codes, normal class
`define ETU_N_ZDIV      4'h0
`define ETU_N_TRACE     4'h1
`define ETU_N_ILLOP     4'h2
`define ETU_N_RSVOP     4'h3
`define ETU_N_INVDESC   4'h4
`define ETU_N_MEMFLT    4'h5
`define ETU_N_GATEVEC   4'h6
`define ETU_N_LVLCHG    4'h7
`define ETU_N_RSVDT     4'h8
`define ETU_N_OVF       4'h9
`define ETU_N_PRIVOP    4'ha
`define ETU_N_BPT       4'he
`define ETU_N_PRIVREG   4'hf
// stack class
`define ETU_S_BOUND     4'h0
`define ETU_S_FAULT     4'h1
`define ETU_S_INTID     4'h3
// process class
`define ETU_P_OLDPCB    4'h0
`define ETU_P_GATEPCB   4'h1
`define ETU_P_NEWPCB    4'h4
// reset class
`define ETU_R_OLDPCB    4'h0
`define ETU_R_SYSDATA   4'h1
`define ETU_R_ISTACK    4'h2
`define ETU_R_EXTRST    4'h3
`define ETU_R_NEWPCB    4'h4
`define ETU_R_GATEVEC   4'h6

// access size codes
`define ETU_SZ_BYTE     2'h0
`define ETU_SZ_HALF     2'h1
`define ETU_SZ_WORD     2'h2

// execution level of the kernel
`define ETU_LVL_KERNEL  2'h0

// register map
`define ETU_CTRL_OFF    4'h0
`define ETU_STAT_OFF    4'h4
`define ETU_CTRL_TE     0
`define ETU_CTRL_OE     1
`define ETU_STAT_CODE   2
`define ETU_STAT_TE     6
`define ETU_STAT_TM     7
`define ETU_STAT_FLAGS  8
`define ETU_STAT_OE     12

`endif

// File: pkg/etu_pkg.sv
// Purpose: carrier types for the exception and trace unit
// Assumes: constants live in etu_consts.svh
// Notes:   none
`default_nettype none
package etu_pkg;

	typedef struct packed {
		logic zero_divide;
		logic illegal_op;
		logic reserved_op;
		logic priv_op;
		logic lit_dest;
		logic ea_of_lit;
		logic ea_of_reg;
		logic reserved_dtype;
		logic gate_ret_raise;
		logic gate_table_fault;
		logic priv_reg_wr;
		logic breakpoint_instr;
	} etu_norm_t;

	typedef struct packed {
		logic       valid;
		logic       fetch;
		logic [1:0] size;
		logic       address_bit_one;
		logic       address_bit_zero;
		logic       ext_fault;
	} etu_acc_t;

	typedef struct packed {
		logic stack_bound;
		logic stack_fault;
		logic intid_fault;
		logic pcb_old_fault;
		logic pcb_gate_fault;
		logic pcb_new_fault;
		logic rst_old_pcb;
		logic rst_sysdata;
		logic rst_istack;
		logic ext_reset;
		logic rst_new_pcb;
		logic rst_gatevec;
	} etu_sys_t;

	typedef struct packed {
		logic [1:0] exception_class_field;
		logic [3:0] internal_state_code;
		logic       trap;
		logic       pc_at_next;
	} etu_rpt_t;

endpackage

`default_nettype wire

// File: tb/test_etu_core.sv
// Purpose: self-checking bench for the exception and trace unit
// Assumes: one wait state on the register bus, events answered one cycle later
// Notes:   expected reports are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "etu_consts.svh"

module test_etu_core
	import etu_pkg::*;
;
	logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i, flags_i, flags_o;
	logic        instr_start_i, instr_end_i, no_trace_instr_i, flags_we_i;
	logic        cop_status_fault_i, cop_no_answer_i, psw_load_i, psw_load_te_i;
	logic        psw_load_oe_i, ctx_switch_i, gate_ret_seq_i, irq_taken_i;
	logic [1:0]  level_i;
	etu_norm_t   norm_i;
	etu_acc_t    acc_i;
	etu_sys_t    sys_i;
	etu_rpt_t    exc_o;
	logic        exc_valid_o, reset_req_o, align_abort_o, irq_inhibit_o, te_o, tm_o, oe_o;
	int          n_errors, checks;
	logic        te_exp;
	etu_rpt_t    q_exc[$];
	logic [31:0] q_rd[$];

	etu_core dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
		.wb_cyc_i, .wb_stb_i, .wb_ack_o, .instr_start_i, .instr_end_i, .no_trace_instr_i,
		.level_i, .norm_i, .acc_i, .cop_status_fault_i, .cop_no_answer_i, .sys_i,
		.flags_we_i, .flags_i, .psw_load_i, .psw_load_te_i, .psw_load_oe_i, .ctx_switch_i,
		.gate_ret_seq_i, .irq_taken_i, .exc_o, .exc_valid_o, .reset_req_o, .align_abort_o,
		.irq_inhibit_o, .te_o, .tm_o, .oe_o, .flags_o);

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic etu_rpt_t rpt(logic [1:0] c, logic [3:0] s, logic t);
		rpt = '{c, s, t, t};
	endfunction

	// monitor: every report and read answer must have been announced by the driver
	always @(posedge clk_i)
	begin
		if (exc_valid_o === 1'b1)
		begin
			if (q_exc.size() == 0)
				chk("unexpected exc_valid_o", 1, 0);
			else
			begin
				chk("exc_o", exc_o, q_exc[0]);
				chk("reset_req_o", reset_req_o, q_exc[0][7:6] == `ETU_CLS_RESET);
				void'(q_exc.pop_front());
			end
		end
		if (wb_ack_o === 1'b1 && !wb_we_i)
		begin
			if (q_rd.size() == 0)
				chk("unexpected read ack", 1, 0);
			else
				chk("wb_dat_o", wb_dat_o, q_rd.pop_front());
		end
	end

	// classic single cycle; held until ack is sampled high
	task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i <= w;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (wb_ack_o !== 1'b1)
		begin
			n_errors++;
			results();
		end
	endtask

	task automatic drain();
		@(posedge clk_i);
		norm_i <= '0;
		sys_i <= '0;
		acc_i <= '0;
		{instr_start_i, instr_end_i, no_trace_instr_i, flags_we_i} <= 4'h0;
		{cop_status_fault_i, cop_no_answer_i} <= 2'h0;
		{ctx_switch_i, gate_ret_seq_i, irq_taken_i} <= 3'h0;
		repeat (3) @(posedge clk_i);
		chk("pending reports", q_exc.size(), 0);
	endtask

	task automatic trace_case(input logic [2:0] clr, input logic nt);
		logic fire;
		fire = te_exp && clr == 3'h0 && !nt;
		@(posedge clk_i);
		instr_start_i <= 1'b1;
		@(posedge clk_i);
		instr_start_i <= 1'b0;
		{ctx_switch_i, gate_ret_seq_i, irq_taken_i} <= clr;
		@(posedge clk_i);
		{ctx_switch_i, gate_ret_seq_i, irq_taken_i} <= 3'h0;
		instr_end_i <= 1'b1;
		no_trace_instr_i <= nt;
		if (fire)
			q_exc.push_back(rpt(`ETU_CLS_NORMAL, `ETU_N_TRACE, 1'b1));
		@(negedge clk_i);
		chk("irq_inhibit_o", irq_inhibit_o, fire);
		chk("te_o", te_o, te_exp);
		chk("tm_o", tm_o, clr == 3'h0);
		drain();
	endtask

	logic [3:0] nc [12] = '{4'h0, 4'h2, 4'h3, 4'ha, 4'h4, 4'h4, 4'h4, 4'h8, 4'h7, 4'h6,
		4'hf, 4'he};
	logic [5:0] sc [12] = '{6'h10, 6'h11, 6'h13, 6'h20, 6'h21, 6'h24, 6'h00, 6'h01,
		6'h02, 6'h03, 6'h04, 6'h06};
	// {valid, fetch, size, bit one, bit zero, ext fault}
	logic [6:0] ac [7] = '{7'h46, 7'h76, 7'h54, 7'h52, 7'h4a, 7'h4c, 7'h51};
	logic [6:0] ab = 7'h1c;
	logic [6:0] af = 7'h1d;

	initial
	begin
		logic [3:0] fl;
		void'($urandom(79154));
		{rst_i, wb_we_i, wb_cyc_i, wb_stb_i} = 4'h8;
		{wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		{instr_start_i, instr_end_i, no_trace_instr_i, flags_we_i, flags_i} = '0;
		{cop_status_fault_i, cop_no_answer_i, psw_load_i, psw_load_te_i, psw_load_oe_i} = '0;
		{ctx_switch_i, gate_ret_seq_i, irq_taken_i, level_i} = '0;
		{norm_i, acc_i, sys_i} = '0;
		te_exp = 1'b0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_sel_i <= 4'hf;
		q_rd.push_back(32'h0000000c);
		wb(32'h4, 0, 1'b0);
		q_rd.push_back(32'h0);
		wb(32'h0, 0, 1'b0);
		wb(32'h8, 32'h3, 1'b1);
		q_rd.push_back(32'h0);
		wb(32'h8, 0, 1'b0);
		q_rd.push_back(32'h0);
		wb(32'h0, 0, 1'b0);
		$display("test reset and register map done");
		for (int i = 0; i < 12; i++)
		begin
			fl = 4'($urandom) & 4'he;
			@(posedge clk_i);
			level_i <= 2'($urandom_range(3, 1));
			flags_we_i <= 1'b1;
			flags_i <= fl;
			@(posedge clk_i);
			flags_we_i <= 1'b0;
			norm_i <= etu_norm_t'(12'h800 >> i);
			instr_end_i <= (i == 11);
			q_exc.push_back(rpt(`ETU_CLS_NORMAL, nc[i], i == 11));
			drain();
			chk("flags_o", flags_o, (i inside {0, 4, 5, 6, 7, 10}) ? 4'h0 : fl);
		end
		@(posedge clk_i);
		level_i <= `ETU_LVL_KERNEL;
		norm_i <= etu_norm_t'(12'h100);
		drain();
		$display("test normal class done");
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clk_i);
			sys_i <= etu_sys_t'(12'h800 >> i);
			norm_i <= etu_norm_t'(12'h400);
			q_exc.push_back(rpt(sc[i][5:4], sc[i][3:0], 1'b0));
			drain();
		end
		$display("test system classes done");
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clk_i);
			acc_i <= etu_acc_t'(ac[i]);
			if (af[6 - i])
				q_exc.push_back(rpt(`ETU_CLS_NORMAL, `ETU_N_MEMFLT, 1'b0));
			@(negedge clk_i);
			chk("align_abort_o", align_abort_o, ab[6 - i]);
			drain();
		end
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk_i);
			{cop_status_fault_i, cop_no_answer_i} <= 2'(i + 1);
			q_exc.push_back(rpt(`ETU_CLS_NORMAL, `ETU_N_MEMFLT, 1'b0));
			drain();
		end
		$display("test memory fault done");
		wb(32'h0, 32'h2, 1'b1);
		chk("oe_o", oe_o, 1'b1);
		@(posedge clk_i);
		{instr_end_i, flags_we_i, flags_i} <= 6'h31;
		q_exc.push_back(rpt(`ETU_CLS_NORMAL, `ETU_N_OVF, 1'b1));
		@(posedge clk_i);
		{instr_end_i, flags_we_i, flags_i} <= 6'h31;
		drain();
		chk("oe_o", oe_o, 1'b0);
		q_rd.push_back(32'h0);
		wb(32'h0, 0, 1'b0);
		$display("test overflow done");
		wb(32'h0, 32'h1, 1'b1);
		te_exp = 1'b1;
		trace_case(3'h0, 1'b0);
		trace_case(3'h0, 1'b1);
		for (int k = 0; k < 3; k++)
			trace_case(3'(1 << k), 1'b0);
		wb(32'h0, 32'h0, 1'b1);
		te_exp = 1'b0;
		trace_case(3'h0, 1'b0);
		$display("test trace done");
		@(posedge clk_i);
		{psw_load_i, psw_load_te_i, psw_load_oe_i} <= 3'h5;
		{flags_we_i, flags_i} <= 5'h11;
		@(posedge clk_i);
		{psw_load_i, flags_we_i} <= 2'h0;
		instr_end_i <= 1'b1;
		q_exc.push_back(rpt(`ETU_CLS_NORMAL, `ETU_N_OVF, 1'b1));
		@(negedge clk_i);
		chk("te_o", te_o, 1'b0);
		chk("oe_o", oe_o, 1'b1);
		drain();
		chk("oe_o", oe_o, 1'b0);
		$display("test status reload done");
		results();
	end
endmodule

`default_nettype wire
